// ### hdl/scs_in_sync.sv
// Three-stage input synchroniser
`default_nettype none
module scs_in_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk_sys,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] ff1_r;
	logic [W-1:0] ff2_r;
	logic [W-1:0] ff3_r;

	// Shift chain
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			ff1_r <= '0;
			ff2_r <= '0;
			ff3_r <= '0;
		end else begin
			ff1_r <= i_async;
			ff2_r <= ff1_r;
			ff3_r <= ff2_r;
		end
	end

	// Change once stages two and three agree
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_sync <= '0;
		end else begin
			o_sync <= (ff3_r & ~(ff2_r ^ ff3_r)) | (o_sync & (ff2_r ^ ff3_r));
		end
	end
endmodule
`default_nettype wire

// ### hdl/scs_pkg.sv
// Servo command scaling package
`default_nettype none
package scs_pkg;
	// Register offsets, one 16-bit word each
	localparam logic [15:0] ADDR_UNIT_SCALING = 16'h023f;
	localparam logic [15:0] ADDR_MIX_MODE     = 16'h0240;
	localparam logic [15:0] ADDR_SPECIAL      = 16'h0241;
	localparam logic [15:0] ADDR_RSVD_A       = 16'h0242;
	localparam logic [15:0] ADDR_RSVD_B       = 16'h0243;
	localparam logic [15:0] ADDR_RSVD_C       = 16'h0244;
	localparam logic [15:0] RST_UNIT_SCALING  = 16'h0000;
	localparam logic [15:0] RST_MIX_MODE      = 16'h0000;
	localparam logic [15:0] RST_SPECIAL       = 16'h0000;

	// Field positions
	localparam int SCL_SPEED_DEC_BIT = 0;
	localparam int SCL_PERR_BIT      = 4;
	localparam int MIX_LO            = 0;
	localparam int SF_SPD_EDGE_BIT   = 0;
	localparam int SF_TRQ_EDGE_BIT   = 1;
	localparam int SF_FAST_NC_BIT    = 2;
	localparam int SF_FAST_FN_LO     = 3;
	localparam int SF_PULSE_OFF_BIT  = 6;
	localparam int SF_CLAMP_SPD_BIT  = 10;

	// Scales and display codes
	localparam logic [3:0]  SPEED_DEC_FACTOR = 4'ha;
	localparam logic [6:0]  PERR_COARSE_MUL  = 7'h64;
	localparam logic [4:0]  DISP_LATCH_PULSES = 5'h0f;
	localparam logic [4:0]  DISP_LATCH_TURNS  = 5'h10;

	// Filter and pulse window timing
	localparam int CLK_PERIOD_NS  = 8;
	localparam int DI_FILT_MIN_NS = 400000;
	localparam int DI_FILT_CYC    = (DI_FILT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_WIN_NS   = 1000000;
	localparam int PULSE_WIN_CYC  = PULSE_WIN_NS / CLK_PERIOD_NS;
	localparam int PULSE_MAX_KPPS = 570;
	localparam int PULSE_MAX_CNT  = PULSE_MAX_KPPS * PULSE_WIN_NS / 1000000;
	localparam int CNT_W          = 17;
	localparam int PCNT_W         = 12;

	// Synchronised input vector layout
	localparam int DI_SPEED_SELECT_INPUT_0  = 0;
	localparam int DI_TORQUE_SELECT_INPUT_0  = 2;
	localparam int DI_TORQUE_LIMIT_ACTIVATE_INPUT = 4;
	localparam int DI_NSEL  = 5;
	localparam int DI_PSEL  = 6;
	localparam int DI_CLAMP = 7;
	localparam int DI_EIGHT = 8;
	localparam int DI_PULSE = 9;
	localparam int DI_W     = 10;
	localparam int DI_ORD_W = 9;

	typedef enum logic [1:0] {
		MIX_OFF = 2'b00,
		MIX_ABS = 2'b01,
		MIX_POS = 2'b10,
		MIX_NEG = 2'b11
	} scs_mix_e;

	typedef enum logic [1:0] {
		FAST_OFF     = 2'b00,
		FAST_LATCH   = 2'b01,
		FAST_INHIBIT = 2'b10,
		FAST_RSVD    = 2'b11
	} scs_fast_e;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} scs_par_req_s;

	typedef struct packed {
		logic [15:0] pos;
		logic [15:0] neg;
	} scs_tq_lim_s;
endpackage
`default_nettype wire

// ### hdl/scs_top.sv
// Servo command scaling and special functions
// How it works
// (R01) Speed presets in 1 or 0.1 r/min
// (R02) Decimal scaling skips speed limit
// (R03) Error threshold unit 1 or 100 pulses
// (R04) Mode 0 off; mode 1 min of |ref|
// (R05) Mode 2: positive ref only, negative zeroes
// (R06) Mode 3: negative ref only, positive zeroes
// (R07) Limit selects use internal limits
// (R08) Speed select by level or rising edge
// (R09) Torque select by level or rising edge
// (R10) Fast input replaces input eight; 00 disables
// (R11) Fast input contact type from bit 2
// (R12) Select 01 latches position, shown 15/16
// (R13) Select 10: fast inhibit
// (R14) Pulse rate over 570 kpps alarms, maskable
// (R15) Reserved bits written as zero
// (R16) Clamp holds position or forces zero speed
// (R17) Clamp needs speed mode, input, low command
// (R18) Edge mode holds until next edge
`default_nettype none
module scs_top #(
	parameter int P_DI_FILT_CYC   = scs_pkg::DI_FILT_CYC,
	parameter int P_PULSE_WIN_CYC = scs_pkg::PULSE_WIN_CYC
) (
	input  wire logic                 i_clk_sys,
	input  wire logic                 i_rst,
	// Parameter access
	input  wire scs_pkg::scs_par_req_s i_par_req,
	output logic               [15:0] o_par_rdata,
	output logic                      o_par_ack,
	output logic                      o_par_err,
	// Pins
	input  wire logic                 i_speed_select_input_0,
	input  wire logic                 i_speed_select_input_1,
	input  wire logic                 i_torque_select_input_0,
	input  wire logic                 i_torque_select_input_1,
	input  wire logic                 i_torque_limit_activate_input,
	input  wire logic                 i_negative_limit_select_input,
	input  wire logic                 i_positive_limit_select_input,
	input  wire logic                 i_zero_clamp,
	input  wire logic                 i_digital_input_eight,
	input  wire logic                 i_pulse_cmd,
	// Drive values
	input  wire logic                 i_speed_mode,
	input  wire logic signed   [19:0] i_analog_speed,
	input  wire logic signed   [15:0] i_int_speed_1,
	input  wire logic signed   [15:0] i_int_speed_2,
	input  wire logic signed   [15:0] i_int_speed_3,
	input  wire logic          [15:0] i_speed_limit,
	input  wire logic          [15:0] i_clamp_thr,
	input  wire logic          [15:0] i_perr_thr,
	input  wire logic          [23:0] i_perr_abs,
	input  wire logic signed   [15:0] i_torque_ref,
	input  wire scs_pkg::scs_tq_lim_s i_src_limit,
	input  wire scs_pkg::scs_tq_lim_s i_int_limit,
	input  wire logic          [31:0] i_motor_pos,
	input  wire logic          [15:0] i_motor_turns,
	input  wire logic           [4:0] i_display_sel,
	input  wire logic                 i_alarm_clr,
	// Results
	output logic signed        [19:0] o_speed_cmd,
	output logic               [15:0] o_speed_limit,
	output logic                [1:0] o_speed_sel,
	output logic                [1:0] o_torque_sel,
	output logic               [23:0] o_perr_thr_pulses,
	output logic                      o_perr_warn,
	output scs_pkg::scs_tq_lim_s      o_tq_limit,
	output logic                      o_tq_limit_en,
	output logic                      o_di8_level,
	output logic                      o_inhibit,
	output logic               [31:0] o_latch_pulses,
	output logic               [15:0] o_latch_turns,
	output logic                      o_latch_event,
	output logic               [31:0] o_display_val,
	output logic                      o_abnormal_pulse_alarm,
	output logic                      o_clamp_active,
	output logic                      o_pos_hold,
	output logic                      o_ramp_keep
);
	localparam logic [scs_pkg::CNT_W-1:0] FILT_LAST =
		scs_pkg::CNT_W'(P_DI_FILT_CYC - 1);
	localparam logic [scs_pkg::CNT_W-1:0] WIN_LAST =
		scs_pkg::CNT_W'(P_PULSE_WIN_CYC - 1);
	localparam logic [scs_pkg::PCNT_W-1:0] PULSE_LIM =
		scs_pkg::PCNT_W'(scs_pkg::PULSE_MAX_CNT);

	// Magnitude
	function automatic logic [19:0] abs20(input logic signed [19:0] v);
		abs20 = v[19] ? 20'(-v) : 20'(v);
	endfunction

	// Smaller limit
	function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
		min16 = (a < b) ? a : b;
	endfunction

	// Preset to 0.1 r/min
	function automatic logic signed [19:0] scale_speed(
		input logic signed [15:0] raw,
		input logic               dec
	);
		logic signed [19:0] ext;
		ext = 20'(raw);
		scale_speed = dec ? ext : 20'(ext * $signed({1'b0, scs_pkg::SPEED_DEC_FACTOR}));
	endfunction

	logic [15:0] unit_scaling_r;
	logic [15:0] mix_mode_r;
	logic [15:0] special_r;
	logic [15:0] rdata_nxt;
	logic        hit;

	logic [scs_pkg::DI_W-1:0]     di_sync;
	logic [scs_pkg::DI_ORD_W-1:0] di_prev_r;
	logic [scs_pkg::DI_ORD_W-1:0] di_filt_r;
	logic [scs_pkg::CNT_W-1:0]    filt_cnt_r;

	logic               dec_mode;
	logic               perr_coarse;
	scs_pkg::scs_mix_e  mix_mode;
	scs_pkg::scs_fast_e fast_fn;
	logic               fast_on;

	// Register map decode
	assign hit = (i_par_req.addr >= scs_pkg::ADDR_UNIT_SCALING) &&
		(i_par_req.addr <= scs_pkg::ADDR_RSVD_C);

	// Control words; reserved ignore writes
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			unit_scaling_r <= scs_pkg::RST_UNIT_SCALING;
			mix_mode_r     <= scs_pkg::RST_MIX_MODE;
			special_r      <= scs_pkg::RST_SPECIAL;
		end else if (i_par_req.wr) begin
			case (i_par_req.addr)
				scs_pkg::ADDR_UNIT_SCALING: unit_scaling_r <= i_par_req.wdata;
				scs_pkg::ADDR_MIX_MODE:     mix_mode_r     <= i_par_req.wdata;
				scs_pkg::ADDR_SPECIAL:      special_r      <= i_par_req.wdata;
				default: ;
			endcase
		end
	end

	// Unused words read zero
	always_comb begin
		case (i_par_req.addr)
			scs_pkg::ADDR_UNIT_SCALING: rdata_nxt = unit_scaling_r;
			scs_pkg::ADDR_MIX_MODE:     rdata_nxt = mix_mode_r;
			scs_pkg::ADDR_SPECIAL:      rdata_nxt = special_r;
			default:                    rdata_nxt = 16'h0000;
		endcase
	end

	// Answer one cycle later
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_par_rdata <= 16'h0000;
			o_par_ack   <= 1'b0;
			o_par_err   <= 1'b0;
		end else begin
			o_par_ack <= i_par_req.wr | i_par_req.rd;
			o_par_err <= (i_par_req.wr | i_par_req.rd) & ~hit;
			if (i_par_req.rd) begin
				o_par_rdata <= rdata_nxt;
			end
		end
	end

	// Fields
	assign dec_mode    = unit_scaling_r[scs_pkg::SCL_SPEED_DEC_BIT];
	assign perr_coarse = unit_scaling_r[scs_pkg::SCL_PERR_BIT];
	assign mix_mode    = scs_pkg::scs_mix_e'(mix_mode_r[scs_pkg::MIX_LO +: 2]);
	assign fast_fn     = scs_pkg::scs_fast_e'(special_r[scs_pkg::SF_FAST_FN_LO +: 2]);
	assign fast_on     = (fast_fn != scs_pkg::FAST_OFF); // [R10]

	// Pin synchroniser
	scs_in_sync #(
		.W (scs_pkg::DI_W)
	) u_sync (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_async   ({i_pulse_cmd, i_digital_input_eight, i_zero_clamp,
			i_positive_limit_select_input, i_negative_limit_select_input,
			i_torque_limit_activate_input, i_torque_select_input_1,
			i_torque_select_input_0, i_speed_select_input_1,
			i_speed_select_input_0}),
		.o_sync    (di_sync)
	);

	// Shared filter counter: small, but one busy pin delays all
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			di_prev_r  <= '0;
			di_filt_r  <= '0;
			filt_cnt_r <= '0;
		end else begin
			di_prev_r <= di_sync[scs_pkg::DI_ORD_W-1:0];
			if (di_sync[scs_pkg::DI_ORD_W-1:0] != di_prev_r) begin
				filt_cnt_r <= '0;
			end else if (filt_cnt_r != FILT_LAST) begin
				filt_cnt_r <= filt_cnt_r + 1'b1;
			end else begin
				di_filt_r <= di_prev_r;
			end
		end
	end

	// Command select latches
	scs_trig_sel u_spd_sel (
		.i_clk_sys   (i_clk_sys),
		.i_rst       (i_rst),
		.i_sel       (di_filt_r[scs_pkg::DI_SPEED_SELECT_INPUT_0 +: 2]),
		.i_edge_mode (special_r[scs_pkg::SF_SPD_EDGE_BIT]), // [R08] [R18]
		.o_sel       (o_speed_sel)
	);

	scs_trig_sel u_trq_sel (
		.i_clk_sys   (i_clk_sys),
		.i_rst       (i_rst),
		.i_sel       (di_filt_r[scs_pkg::DI_TORQUE_SELECT_INPUT_0 +: 2]),
		.i_edge_mode (special_r[scs_pkg::SF_TRQ_EDGE_BIT]), // [R09] [R18]
		.o_sel       (o_torque_sel)
	);

	// Analog on 00, else presets
	logic signed [19:0] spd_sel;
	logic        [20:0] clamp_lim;
	logic               clamp_cond;

	always_comb begin
		case (o_speed_sel)
			2'h1:    spd_sel = scale_speed(i_int_speed_1, dec_mode); // [R01]
			2'h2:    spd_sel = scale_speed(i_int_speed_2, dec_mode); // [R01]
			2'h3:    spd_sel = scale_speed(i_int_speed_3, dec_mode); // [R01]
			default: spd_sel = i_analog_speed;
		endcase
	end

	// Threshold r/min to 0.1 r/min
	assign clamp_lim  = 21'(i_clamp_thr) * 21'(scs_pkg::SPEED_DEC_FACTOR);
	assign clamp_cond = i_speed_mode && di_filt_r[scs_pkg::DI_CLAMP] &&
		({1'b0, abs20(spd_sel)} < clamp_lim); // [R17]

	// Clamp outcome
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_speed_cmd    <= 20'sh00000;
			o_speed_limit  <= 16'h0000;
			o_clamp_active <= 1'b0;
			o_pos_hold     <= 1'b0;
			o_ramp_keep    <= 1'b0;
		end else begin
			o_speed_limit  <= i_speed_limit; // [R02]
			o_clamp_active <= clamp_cond;
			o_pos_hold     <= clamp_cond & ~special_r[scs_pkg::SF_CLAMP_SPD_BIT]; // [R16]
			o_ramp_keep    <= clamp_cond & special_r[scs_pkg::SF_CLAMP_SPD_BIT]; // [R16]
			if (clamp_cond && special_r[scs_pkg::SF_CLAMP_SPD_BIT]) begin
				o_speed_cmd <= 20'sh00000; // [R16]
			end else begin
				o_speed_cmd <= spd_sel;
			end
		end
	end

	// Error threshold in pulses
	logic [23:0] perr_thr;

	assign perr_thr = perr_coarse ?
		24'(i_perr_thr) * 24'(scs_pkg::PERR_COARSE_MUL) : 24'(i_perr_thr); // [R03]

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_perr_thr_pulses <= 24'h000000;
			o_perr_warn       <= 1'b0;
		end else begin
			o_perr_thr_pulses <= perr_thr;
			o_perr_warn       <= i_perr_abs > perr_thr;
		end
	end

	// Separate selects use internal limits
	logic [15:0]          pl_eff;
	logic [15:0]          nl_eff;
	logic [15:0]          tref_mag;
	logic                 tref_pos;
	scs_pkg::scs_tq_lim_s lim_nxt;

	assign pl_eff   = di_filt_r[scs_pkg::DI_PSEL] ? i_int_limit.pos : i_src_limit.pos; // [R07]
	assign nl_eff   = di_filt_r[scs_pkg::DI_NSEL] ? i_int_limit.neg : i_src_limit.neg; // [R07]
	assign tref_mag = abs20(20'(i_torque_ref))[15:0];
	assign tref_pos = ~i_torque_ref[15];

	// Limit mixing
	always_comb begin
		lim_nxt.pos = pl_eff;
		lim_nxt.neg = nl_eff;
		case (mix_mode)
			scs_pkg::MIX_OFF: ; // [R04]
			scs_pkg::MIX_ABS: begin
				lim_nxt.pos = min16(tref_mag, pl_eff); // [R04]
				lim_nxt.neg = min16(tref_mag, nl_eff); // [R04]
			end
			scs_pkg::MIX_POS: begin
				if (tref_pos) begin
					lim_nxt.pos = min16(tref_mag, pl_eff); // [R05]
				end else begin
					lim_nxt.pos = 16'h0000; // [R05]
					lim_nxt.neg = 16'h0000;
				end
			end
			scs_pkg::MIX_NEG: begin
				if (tref_pos && tref_mag != 16'h0000) begin
					lim_nxt.pos = 16'h0000; // [R06]
					lim_nxt.neg = 16'h0000;
				end else begin
					lim_nxt.neg = min16(tref_mag, nl_eff); // [R06]
				end
			end
			default: ;
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_tq_limit    <= '0;
			o_tq_limit_en <= 1'b0;
		end else begin
			o_tq_limit    <= lim_nxt;
			o_tq_limit_en <= di_filt_r[scs_pkg::DI_TORQUE_LIMIT_ACTIVATE_INPUT] |
				di_filt_r[scs_pkg::DI_NSEL] | di_filt_r[scs_pkg::DI_PSEL];
		end
	end

	// Fast input skips filter
	logic fast_act;
	logic fast_prev_r;
	logic fast_edge;

	assign fast_act  = di_sync[scs_pkg::DI_EIGHT] ^ special_r[scs_pkg::SF_FAST_NC_BIT]; // [R11]
	assign fast_edge = fast_act & ~fast_prev_r;

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			fast_prev_r <= 1'b0;
			o_inhibit   <= 1'b0;
			o_di8_level <= 1'b0;
		end else begin
			fast_prev_r <= fast_act;
			o_inhibit   <= (fast_fn == scs_pkg::FAST_INHIBIT) & fast_act; // [R13]
			o_di8_level <= di_filt_r[scs_pkg::DI_EIGHT] & ~fast_on; // [R10]
		end
	end

	// Latch on fast edge
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_latch_pulses <= 32'h00000000;
			o_latch_turns  <= 16'h0000;
			o_latch_event  <= 1'b0;
		end else begin
			o_latch_event <= 1'b0;
			if (fast_fn == scs_pkg::FAST_LATCH && fast_edge) begin
				o_latch_pulses <= i_motor_pos; // [R12]
				o_latch_turns  <= i_motor_turns; // [R12]
				o_latch_event  <= 1'b1;
			end
		end
	end

	// Display of latch
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_display_val <= 32'h00000000;
		end else begin
			case (i_display_sel)
				scs_pkg::DISP_LATCH_PULSES: o_display_val <= o_latch_pulses; // [R12]
				scs_pkg::DISP_LATCH_TURNS:  o_display_val <= 32'(o_latch_turns); // [R12]
				default:                    o_display_val <= 32'h00000000;
			endcase
		end
	end

	// Edges per fixed window
	logic                       pulse_prev_r;
	logic [scs_pkg::CNT_W-1:0]  win_cnt_r;
	logic [scs_pkg::PCNT_W-1:0] pcnt_r;
	logic                       pulse_off;
	logic                       over_rate;

	assign pulse_off = special_r[scs_pkg::SF_PULSE_OFF_BIT];
	assign over_rate = (win_cnt_r == WIN_LAST) && (pcnt_r > PULSE_LIM);

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			pulse_prev_r <= 1'b0;
			win_cnt_r    <= '0;
			pcnt_r       <= '0;
		end else begin
			pulse_prev_r <= di_sync[scs_pkg::DI_PULSE];
			if (win_cnt_r == WIN_LAST) begin
				win_cnt_r <= '0;
				pcnt_r    <= '0;
			end else begin
				win_cnt_r <= win_cnt_r + 1'b1;
				// Saturate, never wrap
				if (di_sync[scs_pkg::DI_PULSE] && !pulse_prev_r && !(&pcnt_r)) begin
					pcnt_r <= pcnt_r + 1'b1;
				end
			end
		end
	end

	// Sticky; detection beats clear
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_abnormal_pulse_alarm <= 1'b0;
		end else if (pulse_off) begin
			o_abnormal_pulse_alarm <= 1'b0; // [R14]
		end else if (over_rate) begin
			o_abnormal_pulse_alarm <= 1'b1; // [R14]
		end else if (i_alarm_clr) begin
			o_abnormal_pulse_alarm <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ### hdl/scs_trig_sel.sv
// Command select latch, by level or by rising edge
`default_nettype none
module scs_trig_sel (
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst,
	input  wire logic [1:0] i_sel,
	input  wire logic       i_edge_mode,
	output logic      [1:0] o_sel
);
	logic [1:0] prev_r;
	logic       rise;

	assign rise = |(i_sel & ~prev_r);

	// Previous combination
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			prev_r <= 2'h0;
		end else begin
			prev_r <= i_sel;
		end
	end

	// Edge mode holds until next rise
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_sel <= 2'h0;
		end else if (!i_edge_mode || rise) begin
			o_sel <= i_sel;
		end
	end
endmodule
`default_nettype wire

// ### test/scs_ctrl_model.sv
// Controller model: input pins and pulse command
`default_nettype none
module scs_ctrl_model (
	input  wire logic       i_clk_sys,
	output var  logic [9:0] o_pins
);
	timeunit 1ns;
	timeprecision 1ps;
	initial o_pins = 10'h000;
	// Pins stand well past the filter
	task automatic set_pins(input logic [8:0] v);
		@(posedge i_clk_sys);
		#1 o_pins[8:0] = v;
		repeat (24) @(posedge i_clk_sys);
		#1;
	endtask
	// Gap cycles per level; one cycle would not pass the synchroniser
	task automatic burst(input int n, input int gap);
		repeat (n) begin
			@(posedge i_clk_sys);
			#1 o_pins[9] = 1'b1;
			repeat (gap) @(posedge i_clk_sys);
			#1 o_pins[9] = 1'b0;
			repeat (gap - 1) @(posedge i_clk_sys);
		end
		#1;
	endtask
endmodule
`default_nettype wire

// ### test/scs_monitor.sv
// Port checker bound to scs_top
`default_nettype none
module scs_monitor (
	input wire logic                  i_clk_sys,
	input wire logic                  i_rst,
	input wire scs_pkg::scs_par_req_s i_par_req,
	input wire logic                  o_par_ack,
	input wire logic                  o_par_err,
	input wire logic                  i_speed_mode,
	input wire logic           [15:0] i_perr_thr,
	input wire logic           [23:0] o_perr_thr_pulses,
	input wire logic                  o_di8_level,
	input wire logic                  o_inhibit,
	input wire logic                  o_latch_event,
	input wire logic                  o_abnormal_pulse_alarm,
	input wire logic                  o_clamp_active,
	input wire logic                  o_pos_hold,
	input wire logic                  o_ramp_keep
);
	logic [15:0] scl_r;
	logic [15:0] sf_r;
	default clocking @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);
	// Shadow of the unit scaling and special function writes; mix mode not shadowed
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			scl_r <= 16'h0000;
			sf_r  <= 16'h0000;
		end else if (i_par_req.wr && i_par_req.addr == scs_pkg::ADDR_UNIT_SCALING) begin
			scl_r <= i_par_req.wdata;
		end else if (i_par_req.wr && i_par_req.addr == scs_pkg::ADDR_SPECIAL) begin
			sf_r <= i_par_req.wdata;
		end
	end
	// Request; unmapped request
	sequence s_req;
		i_par_req.wr || i_par_req.rd;
	endsequence
	sequence s_bad;
		s_req ##0 (i_par_req.addr < 16'h023f || i_par_req.addr > 16'h0244);
	endsequence
	AST_ACK: assert property (s_req |=> o_par_ack)
		else $error("no ack");
	AST_ERR: assert property (s_bad |=> o_par_err && o_par_ack)
		else $error("no error");
	AST_PERR_UNIT: assert property (!$past(i_rst) && $stable(scl_r) && $stable(i_perr_thr)
		|-> o_perr_thr_pulses == (scl_r[4] ? 24'(i_perr_thr) * 24'h000064 : 24'(i_perr_thr)))
		else $error("threshold unit wrong");
	AST_DI8_DROP: assert property (sf_r[4:3] != 2'b00 && $past(sf_r[4:3]) != 2'b00
		|-> !o_di8_level)
		else $error("input eight kept");
	AST_LATCH_ONLY: assert property ((sf_r[4:3] != 2'b01)[*8] |-> !o_latch_event)
		else $error("stray latch");
	AST_INHIBIT_ONLY: assert property ((sf_r[4:3] != 2'b10)[*8] |-> !o_inhibit)
		else $error("stray inhibit");
	AST_ALARM_MASK: assert property (sf_r[6] && $past(sf_r[6]) |-> !o_abnormal_pulse_alarm)
		else $error("alarm while masked");
	AST_CLAMP_MODE: assert property (!$past(i_speed_mode) && !$past(i_speed_mode, 2)
		|-> !o_clamp_active)
		else $error("clamp outside speed mode");
	AST_CLAMP_KIND: assert property (o_clamp_active && $past(o_clamp_active)
		&& $stable(sf_r[10]) |-> o_ramp_keep == sf_r[10] && o_pos_hold == !sf_r[10])
		else $error("clamp behaviour wrong");
endmodule
bind scs_top scs_monitor u_mon (.*);
`default_nettype wire

// ### test/scs_top_tb.sv
// Self-checking bench for scs_top
`default_nettype none
module scs_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  i_clk_sys, i_rst, i_speed_mode, i_alarm_clr;
	logic                  i_speed_select_input_0, i_speed_select_input_1;
	logic                  i_torque_select_input_0, i_torque_select_input_1;
	logic                  i_torque_limit_activate_input, i_negative_limit_select_input;
	logic                  i_positive_limit_select_input, i_zero_clamp;
	logic                  i_digital_input_eight, i_pulse_cmd;
	scs_pkg::scs_par_req_s i_par_req;
	scs_pkg::scs_tq_lim_s  i_src_limit, i_int_limit, o_tq_limit;
	logic signed [19:0]    i_analog_speed, o_speed_cmd;
	logic signed [15:0]    i_int_speed_1, i_int_speed_2, i_int_speed_3, i_torque_ref;
	logic [15:0]           i_speed_limit, i_clamp_thr, i_perr_thr, i_motor_turns;
	logic [15:0]           o_par_rdata, o_speed_limit, o_latch_turns, rq;
	logic [23:0]           i_perr_abs, o_perr_thr_pulses;
	logic [31:0]           i_motor_pos, o_latch_pulses, o_display_val;
	logic [9:0]            pins;
	logic [4:0]            i_display_sel;
	logic [1:0]            o_speed_sel, o_torque_sel;
	logic                  o_par_ack, o_par_err, o_perr_warn, o_tq_limit_en, o_di8_level;
	logic                  o_inhibit, o_latch_event, o_abnormal_pulse_alarm;
	logic                  o_clamp_active, o_pos_hold, o_ramp_keep;
	int                    n_fail, num_checks;
	logic [15:0] adr [7] = '{16'h023f, 16'h0240, 16'h0241, 16'h0242, 16'h0243, 16'h0244, 16'h0245};
	// {pos, neg} per mode, ref +300 then -300
	logic [31:0] mix_exp [8] = '{32'h00c801f4, 32'h00c801f4, 32'h00c8012c, 32'h00c8012c,
		32'h00c801f4, 32'h00000000, 32'h00000000, 32'h00c8012c};
	// Select pins and result; steps 1..4 edge mode
	logic [1:0] sel_in [6] = '{2'h1, 2'h0, 2'h2, 2'h3, 2'h1, 2'h1};
	logic [1:0] sel_ex [6] = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h3, 2'h1};
	assign {i_pulse_cmd, i_digital_input_eight, i_zero_clamp, i_positive_limit_select_input,
		i_negative_limit_select_input, i_torque_limit_activate_input, i_torque_select_input_1,
		i_torque_select_input_0, i_speed_select_input_1, i_speed_select_input_0} = pins;
	scs_ctrl_model ctl (.i_clk_sys(i_clk_sys), .o_pins(pins));
	// Short filter, short window
	scs_top #(.P_DI_FILT_CYC(4), .P_PULSE_WIN_CYC(2400)) DUT (.*);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One access; ack and err stand one cycle
	task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
		@(posedge i_clk_sys);
		#1 i_par_req = {w, !w, a, d};
		@(posedge i_clk_sys);
		#1 i_par_req = '0;
		rq = o_par_rdata;
		chk(o_par_ack, 1);
		chk(o_par_err, (a < 16'h023f || a > 16'h0244));
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		i_clk_sys = 1'b0;
		forever #4 i_clk_sys = ~i_clk_sys;
	end
	// Watchdog
	initial begin
		cyc(60000);
		n_fail++;
		wrap_up();
	end
	initial begin
		{i_rst, i_speed_mode, i_alarm_clr} = 3'h4;
		i_par_req = '0;
		{i_analog_speed, i_int_speed_2, i_int_speed_3} = {20'h00309, 16'h0064, 16'h00c8};
		{i_int_speed_1, i_torque_ref, i_speed_limit} = {16'h04d2, 16'h0000, 16'h0bb8};
		{i_clamp_thr, i_perr_thr, i_perr_abs} = {16'h000a, 16'h0000, 24'h000000};
		{i_src_limit, i_int_limit} = {32'h00c801f4, 32'h01900258};
		{i_motor_pos, i_motor_turns, i_display_sel} = {32'h0, 16'h0, 5'h00};
		{n_fail, num_checks} = {32'h0, 32'h0};
		cyc(10);
		i_rst = 1'b0;
		// Reset values, read back, reserved and unmapped
		foreach (adr[i]) begin
			acc(0, adr[i], 16'h0000);
			chk(rq, 16'h0000);
			acc(1, adr[i], 16'h0003);
			acc(0, adr[i], 16'h0000);
			chk(rq, i < 3 ? 16'h0003 : 16'h0000);
		end
		for (int i = 0; i < 3; i++)
			acc(1, adr[i], 16'h0000);
		$display("test registers done");
		// Presets times ten unless decimal; limit, analog never
		ctl.set_pins(9'h001);
		chk(o_speed_sel, 2'h1);
		chk(o_speed_cmd, 20'h03034);
		acc(1, 16'h023f, 16'h0001);
		cyc(4);
		chk(o_speed_cmd, 20'h004d2);
		chk(o_speed_limit, 16'h0bb8);
		i_speed_limit = 16'h07d0;
		i_analog_speed = 20'h00064;
		ctl.set_pins(9'h000);
		chk(o_speed_cmd, 20'h00064);
		chk(o_speed_limit, 16'h07d0);
		$display("test speed scaling done");
		// Threshold 1000 in 100 pulses, then 1
		i_perr_thr = 16'h03e8;
		i_perr_abs = 24'h0186a1;
		acc(1, 16'h023f, 16'h0010);
		cyc(4);
		chk(o_perr_thr_pulses, 24'h0186a0);
		chk(o_perr_warn, 1);
		acc(1, 16'h023f, 16'h0000);
		cyc(4);
		chk(o_perr_thr_pulses, 24'h0003e8);
		$display("test error threshold done");
		// All mixing modes, both signs
		ctl.set_pins(9'h010);
		for (int m = 0; m < 8; m++) begin
			acc(1, 16'h0240, 16'(m >> 1));
			i_torque_ref = m[0] ? 16'hfed4 : 16'h012c;
			cyc(4);
			chk(o_tq_limit, mix_exp[m]);
		end
		acc(1, 16'h0240, 16'h0000);
		ctl.set_pins(9'h060);
		chk(o_tq_limit, 32'h01900258);
		chk(o_tq_limit_en, 1);
		$display("test torque limits done");
		// Level, edge, level
		for (int k = 0; k < 6; k++) begin
			if (k == 1)
				acc(1, 16'h0241, 16'h0003);
			if (k == 5)
				acc(1, 16'h0241, 16'h0000);
			ctl.set_pins({5'h00, sel_in[k], sel_in[k]});
			chk({o_torque_sel, o_speed_sel}, {sel_ex[k], sel_ex[k]});
		end
		$display("test trigger modes done");
		// Clamp conditions
		i_speed_mode = 1'b1;
		ctl.set_pins(9'h081);
		chk(o_clamp_active, 0);
		i_int_speed_1 = 16'h0005;
		cyc(4);
		chk({o_clamp_active, o_pos_hold, o_ramp_keep}, 3'h6);
		acc(1, 16'h0241, 16'h0400);
		cyc(4);
		chk({o_clamp_active, o_pos_hold, o_ramp_keep, o_speed_cmd}, {3'h5, 20'h0});
		i_speed_mode = 1'b0;
		cyc(4);
		chk(o_clamp_active, 0);
		$display("test zero clamp done");
		// Fast input latch, display, inhibit
		ctl.set_pins(9'h100);
		chk(o_di8_level, 1);
		i_motor_pos = 32'h12345678;
		i_motor_turns = 16'h0042;
		acc(1, 16'h0241, 16'h0008);
		ctl.set_pins(9'h000);
		chk(o_latch_pulses, 32'h0);
		ctl.set_pins(9'h100);
		chk(o_di8_level, 0);
		chk(o_latch_pulses, 32'h12345678);
		chk(o_latch_turns, 16'h0042);
		i_display_sel = 5'h0f;
		cyc(3);
		chk(o_display_val, 32'h12345678);
		i_display_sel = 5'h10;
		cyc(3);
		chk(o_display_val, 32'h00000042);
		i_motor_pos = 32'h0000abcd;
		acc(1, 16'h0241, 16'h000c);
		ctl.set_pins(9'h000);
		chk(o_latch_pulses, 32'h0000abcd);
		acc(1, 16'h0241, 16'h0010);
		ctl.set_pins(9'h100);
		chk(o_inhibit, 1);
		acc(1, 16'h0241, 16'h0014);
		cyc(8);
		chk(o_inhibit, 0);
		$display("test fast input done");
		// Pulse alarm mask, slow, fast, clear
		acc(1, 16'h0241, 16'h0040);
		ctl.burst(1500, 2);
		chk(o_abnormal_pulse_alarm, 0);
		cyc(2500);
		acc(1, 16'h0241, 16'h0000);
		ctl.burst(1000, 3);
		chk(o_abnormal_pulse_alarm, 0);
		ctl.burst(1500, 2);
		chk(o_abnormal_pulse_alarm, 1);
		i_alarm_clr = 1'b1;
		cyc(2);
		i_alarm_clr = 1'b0;
		cyc(2);
		chk(o_abnormal_pulse_alarm, 0);
		$display("test pulse alarm done");
		wrap_up();
	end
endmodule
`default_nettype wire
